// ### design/sic_pkg.sv
package sic_pkg;
    // I/O ports whose write clears the floating point error interrupt
    localparam logic [15:0] FPU_CLR_PORT_A = 16'h00F0;
    localparam logic [15:0] FPU_CLR_PORT_B = 16'h00F1;
    // Serial packet framing: start bit, payload, stop bit
    localparam int PKT_BITS = 8;
    localparam logic [3:0] PKT_LAST = 4'h8;
    localparam logic [3:0] PKT_ZERO = 4'h0;
    // Suspend depth encodings
    localparam logic SUSPEND_REQ_N_CORE_ONLY = 1'b0;
    localparam logic SUSPEND_REQ_N_ALL_CLOCKS = 1'b1;
    typedef enum logic [1:0] {RUN, DRAIN, SUSPENDED} sic_suspend_req_n_t;
endpackage

// ### design/sic_suspend_interrupt_control.sv
`timescale 1ns/1ps
// How it works
// - A floating point error sets the error interrupt output, which holds until cleared.
// - An I/O write to port F0h or F1h clears the error interrupt output unless a floating point error comes in the same cycle.
// - A low level on the management interrupt input puts the block into management mode.
// - After a suspend request the block waits for the current and decoded work and bus cycles to finish.
// - After reset the suspend request is ignored until the suspend pin enable bit is set.
// - Suspend acknowledge goes active once suspend is really entered, by request or by halt.
// - Suspend acknowledge is only driven active while the suspend pin enable bit is set.
// - The suspend depth selects stopping only core clocks or all internal clocks.
// - Status leaves on one serial wire timed by this clock, with no separate transmit clock.
// - The serial wire carries packets of miscellaneous status for emulation handlers.
module sic_suspend_interrupt_control (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic fpuError,
    input wire logic ioWrite,
    input wire logic [15:0] ioAddr,
    input wire logic sys_mgmt_irq_n,
    input wire logic smmExit,
    input wire logic suspend_req_n,
    input wire logic haltExec,
    input wire logic wakeEvent,
    input wire logic pipeIdle,
    input wire logic clocksRunning,
    input wire logic cfgWrite,
    input wire logic suspend_pin_enable,
    input wire logic suspendDepth,
    input wire logic pktSend,
    input wire logic [7:0] pktData,
    output logic fpu_error_irq,
    output logic sys_mgmt_mode,
    output logic suspend_ack_n,
    output logic coreClockStop,
    output logic allClockStop,
    output logic companion_serial_out,
    output logic pktBusy
);
    logic fpuIrq_reg;
    logic smm_reg;
    logic enable_reg;
    logic depth_reg;
    logic ackN_reg;
    logic coreStop_reg;
    logic allStop_reg;
    logic serial_reg;
    logic busy_reg;
    logic [3:0] bitCnt_reg;
    logic [8:0] shift_reg;
    logic suspReq;
    logic clearHit;
    logic enterSusp;
    logic leaveSusp;
    logic pktStart;
    logic pktEnd;
    sic_pkg::sic_suspend_req_n_t state_reg;

    function automatic logic isClearPort(input logic [15:0] addr);
        isClearPort = (addr == sic_pkg::FPU_CLR_PORT_A) || (addr == sic_pkg::FPU_CLR_PORT_B);
    endfunction

    assign clearHit = ioWrite && isClearPort(ioAddr);
    assign suspReq = enable_reg && !suspend_req_n;

    // Error flag: a new error wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fpuIrq_reg <= 1'b0;
        end else if (fpuError) begin
            fpuIrq_reg <= 1'b1;
        end else if (clearHit) begin
            fpuIrq_reg <= 1'b0;
        end
    end

    // Level-sensitive management entry; leave only when request gone and exit seen
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            smm_reg <= 1'b0;
        end else if (!sys_mgmt_irq_n) begin
            smm_reg <= 1'b1;
        end else if (smmExit) begin
            smm_reg <= 1'b0;
        end
    end

    // Configuration: enable bit clear after reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enable_reg <= 1'b0;
            depth_reg <= sic_pkg::SUSPEND_REQ_N_CORE_ONLY;
        end else if (cfgWrite) begin
            enable_reg <= suspend_pin_enable;
            depth_reg <= suspendDepth;
        end
    end

    // Suspend entry once drained, exit once the request is gone, clocks run and no halt is pending without a wake event
    assign enterSusp = (state_reg == sic_pkg::DRAIN) && pipeIdle;
    assign leaveSusp = (state_reg == sic_pkg::SUSPENDED) && clocksRunning && !suspReq && (!haltExec || wakeEvent);

    // Suspend state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= sic_pkg::RUN;
        end else begin
            unique case (state_reg)
                sic_pkg::RUN: begin
                    if (suspReq || haltExec) begin
                        state_reg <= sic_pkg::DRAIN;
                    end
                end

                sic_pkg::DRAIN: begin
                    if (enterSusp) begin
                        state_reg <= sic_pkg::SUSPENDED;
                    end
                end

                sic_pkg::SUSPENDED: begin
                    if (leaveSusp) begin
                        state_reg <= sic_pkg::RUN;
                    end
                end

                // The fourth code of the state word is unused
                default: begin
                    state_reg <= sic_pkg::RUN;
                end
            endcase
        end
    end

    // Acknowledge only goes active with the pin enable set
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ackN_reg <= 1'b1;
        end else if (enterSusp) begin
            ackN_reg <= !enable_reg;
        end else if (leaveSusp) begin
            ackN_reg <= 1'b1;
        end
    end

    // Core clocks stop in either suspend depth
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            coreStop_reg <= 1'b0;
        end else if (enterSusp) begin
            coreStop_reg <= 1'b1;
        end else if (leaveSusp) begin
            coreStop_reg <= 1'b0;
        end
    end

    // All clocks stop only in the deep setting, which lets the system stop its clock
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            allStop_reg <= 1'b0;
        end else if (enterSusp) begin
            allStop_reg <= (depth_reg == sic_pkg::SUSPEND_REQ_N_ALL_CLOCKS);
        end else if (leaveSusp) begin
            allStop_reg <= 1'b0;
        end
    end

    // Packet accepted only while the line is idle
    assign pktStart = !busy_reg && pktSend;
    assign pktEnd = busy_reg && (bitCnt_reg == sic_pkg::PKT_LAST);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_reg <= 1'b0;
        end else if (pktStart) begin
            busy_reg <= 1'b1;
        end else if (pktEnd) begin
            busy_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bitCnt_reg <= sic_pkg::PKT_ZERO;
        end else if (pktStart) begin
            bitCnt_reg <= sic_pkg::PKT_ZERO;
        end else if (busy_reg) begin
            bitCnt_reg <= bitCnt_reg + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shift_reg <= '1;
        end else if (pktStart) begin
            shift_reg <= {1'b1, pktData};
        end else if (busy_reg) begin
            shift_reg <= {1'b1, shift_reg[8:1]};
        end
    end

    // Low start bit, eight data bits LSB first, line idles high
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            serial_reg <= 1'b1;
        end else if (pktStart) begin
            serial_reg <= 1'b0;
        end else if (busy_reg) begin
            serial_reg <= shift_reg[0];
        end
    end

    // Outputs come straight from their flip-flops
    assign fpu_error_irq = fpuIrq_reg;
    assign sys_mgmt_mode = smm_reg;
    assign suspend_ack_n = ackN_reg;
    assign coreClockStop = coreStop_reg;
    assign allClockStop = allStop_reg;
    assign companion_serial_out = serial_reg;
    assign pktBusy = busy_reg;
endmodule

// ### tb/sic_checker.sv
`timescale 1ns/1ps
module sic_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic fpuError,
    input wire logic ioWrite,
    input wire logic sys_mgmt_irq_n,
    input wire logic suspend_req_n,
    input wire logic pipeIdle,
    input wire logic pktSend,
    input wire logic [15:0] ioAddr,
    input wire logic fpu_error_irq,
    input wire logic sys_mgmt_mode,
    input wire logic suspend_ack_n,
    input wire logic coreClockStop,
    input wire logic companion_serial_out,
    input wire logic pktBusy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire clrHit = ioWrite && (ioAddr == 16'h00F0 || ioAddr == 16'h00F1);
    chk_irq_set: assert property (fpuError |=> fpu_error_irq) else $error("irq not set");
    chk_irq_hold: assert property (fpu_error_irq && !clrHit |=> fpu_error_irq) else $error("irq dropped");
    chk_irq_clear: assert property (clrHit && !fpuError |=> !fpu_error_irq) else $error("irq kept");
    chk_smm_enter: assert property (!sys_mgmt_irq_n |=> sys_mgmt_mode) else $error("no mgmt mode");
    chk_drain_wait: assert property ($fell(suspend_ack_n) |-> $past(pipeIdle)) else $error("ack early");
    chk_ack_stops: assert property (!suspend_ack_n |-> coreClockStop) else $error("core runs");
    chk_ack_hold: assert property (!suspend_ack_n && !suspend_req_n |=> !suspend_ack_n) else $error("ack lost");
    chk_pkt_start: assert property (pktSend && !pktBusy |=> !companion_serial_out && pktBusy)
        else $error("no start bit");
    chk_pkt_len: assert property ($rose(pktBusy) |-> pktBusy[*8] ##1 pktBusy ##1 !pktBusy)
        else $error("bad packet length");
    chk_idle_high: assert property (!pktBusy |-> companion_serial_out) else $error("line not idle");
    cover property ($fell(fpu_error_irq));
    cover property ($fell(suspend_ack_n));
    cover property ($rose(pktBusy));
endmodule
bind sic_suspend_interrupt_control sic_checker i_chk (.clk, .rst_n, .fpuError, .ioWrite, .sys_mgmt_irq_n,
    .suspend_req_n, .pipeIdle, .pktSend, .ioAddr, .fpu_error_irq, .sys_mgmt_mode, .suspend_ack_n,
    .coreClockStop, .companion_serial_out, .pktBusy);

// ### tb/sic_companion_model.sv
`timescale 1ns/1ps
module sic_companion_model (
    input wire logic clk,
    input wire logic serialIn,
    output logic [7:0] rxByte = 8'h00,
    output logic rxDone = 1'b0
);
    int bitCnt = 0;
    // One bit per clock edge, no transmit strobe
    always @(posedge clk) begin
        rxDone <= 1'b0;
        if (bitCnt == 0) bitCnt <= (serialIn === 1'b0) ? 1 : 0;
        else if (bitCnt < 9) begin
            rxByte <= {serialIn, rxByte[7:1]};
            bitCnt <= bitCnt + 1;
        end else begin
            rxDone <= serialIn;
            bitCnt <= 0;
        end
    end
endmodule

// ### tb/suspend_interrupt_control_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) tests_run++; if ((a) !== (e)) begin failures++; $display("Error %s exp %h got %h", n, e, a); end
module suspend_interrupt_control_tb;
    logic clk = 0, rst_n = 0, fpuError = 0, ioWrite = 0, sys_mgmt_irq_n = 1, smmExit = 0, suspend_req_n = 1;
    logic haltExec = 0, wakeEvent = 0, pipeIdle = 0, clocksRunning = 1, cfgWrite = 0, suspend_pin_enable = 0;
    logic suspendDepth = 0, pktSend = 0, rxDone, fpu_error_irq, sys_mgmt_mode, suspend_ack_n, coreClockStop;
    logic allClockStop, companion_serial_out, pktBusy;
    logic [15:0] ioAddr = 16'h0000;
    logic [7:0] pktData = 8'h00, rxByte;
    int failures = 0, tests_run = 0;
    always #2 clk = ~clk;
    sic_suspend_interrupt_control i_dut (.clk, .rst_n, .fpuError, .ioWrite, .ioAddr, .sys_mgmt_irq_n, .smmExit,
        .suspend_req_n, .haltExec, .wakeEvent, .pipeIdle, .clocksRunning, .cfgWrite, .suspend_pin_enable,
        .suspendDepth, .pktSend, .pktData, .fpu_error_irq, .sys_mgmt_mode, .suspend_ack_n, .coreClockStop,
        .allClockStop, .companion_serial_out, .pktBusy);
    sic_companion_model i_comp (.clk, .serialIn(companion_serial_out), .rxByte, .rxDone);
    task automatic wr(input logic [15:0] a, input logic err);
        @(posedge clk) ioWrite <= ~err; ioAddr <= a; fpuError <= err;
        @(posedge clk) ioWrite <= 1'b0; fpuError <= 1'b0;
        @(negedge clk);
    endtask
    task automatic t_irq;
        wr(16'h00F0, 1'b1);
        `CHK("irq set", 1'b1, fpu_error_irq)
        wr(16'h00F2, 1'b0);
        `CHK("irq hold", 1'b1, fpu_error_irq)
        wr(16'h00F1, 1'b0);
        `CHK("irq clr F1", 1'b0, fpu_error_irq)
        wr(16'h00F0, 1'b1);
        wr(16'h00F0, 1'b0);
        `CHK("irq clr F0", 1'b0, fpu_error_irq)
        @(posedge clk) fpuError <= 1'b1; ioWrite <= 1'b1; ioAddr <= 16'h00F1;
        @(posedge clk) fpuError <= 1'b0; ioWrite <= 1'b0;
        @(negedge clk) `CHK("irq set beats clr", 1'b1, fpu_error_irq)
        $display("irq test done");
    endtask
    task automatic t_smm;
        @(posedge clk) sys_mgmt_irq_n <= 1'b0;
        repeat (2) @(negedge clk);
        `CHK("mgmt mode", 1'b1, sys_mgmt_mode)
        @(posedge clk) sys_mgmt_irq_n <= 1'b1; smmExit <= 1'b1;
        @(posedge clk) smmExit <= 1'b0;
        @(negedge clk) `CHK("mgmt exit", 1'b0, sys_mgmt_mode)
        $display("mgmt test done");
    endtask
    task automatic t_suspend_req_n;
        @(posedge clk) suspend_req_n <= 1'b0; pipeIdle <= 1'b1;
        repeat (4) @(negedge clk);
        `CHK("ack disabled", 1'b1, suspend_ack_n)
        `CHK("no stop disabled", 1'b0, coreClockStop)
        for (int d = 1; d >= 0; d--) begin
            @(posedge clk) suspend_req_n <= 1'b1; pipeIdle <= 1'b0; cfgWrite <= 1'b1;
            suspend_pin_enable <= 1'b1; suspendDepth <= d[0];
            @(posedge clk) cfgWrite <= 1'b0; suspend_req_n <= 1'b0;
            repeat (4) @(negedge clk);
            `CHK("ack while busy", 1'b1, suspend_ack_n)
            @(posedge clk) pipeIdle <= 1'b1;
            repeat (2) @(negedge clk);
            `CHK("ack", 1'b0, suspend_ack_n)
            `CHK("core stop", 1'b1, coreClockStop)
            `CHK("depth", d[0], allClockStop)
            // System clock is stopped only in the all-clocks depth
            @(posedge clk) suspend_req_n <= 1'b1; clocksRunning <= ~d[0];
            repeat (3) @(negedge clk);
            `CHK("ack clocks off", ~d[0], suspend_ack_n)
            @(posedge clk) clocksRunning <= 1'b1;
            repeat (2) @(negedge clk);
            `CHK("ack resume", 1'b1, suspend_ack_n)
        end
        @(posedge clk) cfgWrite <= 1'b1; suspend_pin_enable <= 1'b0; haltExec <= 1'b1;
        @(posedge clk) cfgWrite <= 1'b0;
        repeat (3) @(negedge clk);
        `CHK("halt stop", 1'b1, coreClockStop)
        `CHK("halt ack off", 1'b1, suspend_ack_n)
        @(posedge clk) wakeEvent <= 1'b1;
        @(posedge clk) wakeEvent <= 1'b0; haltExec <= 1'b0;
        @(negedge clk) `CHK("halt wake", 1'b0, coreClockStop)
        $display("suspend test done");
    endtask
    task automatic t_pkt;
        @(posedge clk) pktSend <= 1'b1; pktData <= 8'hA5;
        @(posedge clk) pktSend <= 1'b0;
        repeat (2) @(posedge clk);
        pktSend <= 1'b1; pktData <= 8'h3C;
        @(posedge clk) pktSend <= 1'b0;
        for (int i = 0; i < 20 && rxDone !== 1'b1; i++) @(negedge clk);
        `CHK("packet byte", 8'hA5, rxByte)
        repeat (12) @(negedge clk);
        `CHK("refused send", 1'b0, pktBusy)
        `CHK("refused byte", 8'hA5, rxByte)
        $display("packet test done");
    endtask
    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #20000 failures++;
        tally_and_finish;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_irq;
        t_smm;
        t_suspend_req_n;
        t_pkt;
        tally_and_finish;
    end
endmodule
